// ===== core/spi_energy_detect.sv
// Energy-detect low-power sequencer with periodic pulse wake-ups.
// Assumes line activity is a synchronous level from the analog front end.
`timescale 1ns/1ps
`default_nettype none
module spi_energy_detect
    import spi_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_enable,
    input wire logic i_activity,
    output logic o_low_power,
    output logic o_pulse,
    output logic o_state_change
);
    spi_ed_state_t state;
    spi_ed_state_t next_state;
    logic [CNT_W-1:0] cnt;
    wire cnt_period = (cnt == CNT_W'(PULSE_PERIOD_CYC - 1));
    wire cnt_width = (cnt == CNT_W'(PULSE_WIDTH_CYC - 1));
    wire cnt_powerup = (cnt == CNT_W'(POWERUP_CYC - 1));

    always_comb begin
        next_state = state;
        case (state)
            ED_ACTIVE: begin
                if (i_enable && !i_activity) begin
                    next_state = ED_SLEEP;
                end
            end
            ED_SLEEP: begin
                if (!i_enable || i_activity) begin
                    next_state = ED_WAKE;
                end else if (cnt_period) begin
                    next_state = ED_PULSE;
                end
            end
            ED_PULSE: begin
                if (cnt_width) begin
                    next_state = ED_SLEEP;
                end
            end
            ED_WAKE: begin
                if (cnt_powerup) begin
                    next_state = ED_ACTIVE;
                end
            end
            default: begin
                next_state = ED_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= ED_ACTIVE;
            cnt <= '0;
            o_low_power <= 1'b0;
            o_pulse <= 1'b0;
            o_state_change <= 1'b0;
        end else if (i_ce) begin
            state <= next_state;
            cnt <= (next_state != state) ? '0 : cnt + 1'b1;
            o_low_power <= (next_state == ED_SLEEP) || (next_state == ED_PULSE);
            o_pulse <= (next_state == ED_PULSE);
            o_state_change <= ((next_state == ED_SLEEP) && (state == ED_ACTIVE))
                || ((next_state == ED_WAKE) && (state == ED_SLEEP));
        end
    end
endmodule
`default_nettype wire

// ===== core/spi_irq_flags.sv
// Sticky interrupt flags with read-clear; set wins over clear.
// Assumes events are one-cycle pulses from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module spi_irq_flags
    import spi_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [NUM_SOURCES-1:0] i_event,
    input wire logic i_clear,
    output logic [NUM_SOURCES-1:0] o_flags
);
    genvar g;
    generate
        for (g = 0; g < NUM_SOURCES; g = g + 1) begin : g_flag
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    o_flags[g] <= 1'b0;
                end else if (i_ce) begin
                    if (i_event[g]) begin
                        o_flags[g] <= 1'b1;
                    end else if (i_clear) begin
                        o_flags[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== core/spi_pkg.sv
// Package for the power-down / interrupt pin block: register map, fields, timing.
// Assumes a 40 MHz clock and 16-bit management register accesses.
package spi_pkg;
    localparam logic [4:0] ADDR_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_PIN_CONTROL = 5'h11;
    localparam logic [4:0] ADDR_MASK_STATUS = 5'h12;
    localparam logic [4:0] ADDR_ENERGY_CONTROL = 5'h1d;
    localparam int BIT_POWER_DOWN = 11;
    localparam int BIT_PIN_OE = 0;
    localparam int BIT_IRQ_ENABLE = 1;
    localparam int NUM_SOURCES = 8;
    localparam int SRC_LINK = 5;
    localparam int SRC_ENERGY = 6;
    localparam int BIT_ENERGY_ENABLE = 15;
    localparam logic [15:0] RESET_ZERO = 16'h0000;
    localparam int CLK_MHZ = 40;
    localparam int PULSE_PERIOD_US = 16000;
    localparam int PULSE_WIDTH_NS = 100;
    localparam int POWERUP_US = 10;
    localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_US * CLK_MHZ;
    localparam int PULSE_WIDTH_CYC = (PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
    localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
    localparam int CNT_W = 20;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } spi_req_t;

    typedef enum {
        ED_ACTIVE,
        ED_SLEEP,
        ED_PULSE,
        ED_WAKE
    } spi_ed_state_t;
endpackage

// ===== core/spi_powerdown_irq.sv
// Top of the shared power-down / interrupt pin logic with its management registers.
// Assumes register requests are single-cycle strobes synchronous to I_CLK.
//
// How it works
// - Pin is power-down input after reset.
// - Pin output enable bit drives active-low interrupt.
// - Low input pin forces power-down mode.
// - Registers work powered down; enable bit exits.
// - Pin low at initialization starts powered down.
// - All mask bits clear after reset.
// - Global enable and per-source masks gate interrupts.
// - Interrupt pin asserts without waiting extra cycles.
// - High byte shows pending flag per source.
// - Status read clears pending flags, except one whose event fires in the read cycle.
// - Cleared flags release pin high.
// - Link and energy changes are maskable sources.
// - Energy detect idles low-power while monitoring.
// - Line activity triggers normal power-up.
// - Periodic energy-detect pulses in energy mode.
// - Energy saving control register configures detection.
`timescale 1ns/1ps
`default_nettype none
module spi_powerdown_irq
    import spi_pkg::*;
(
    // Clock, reset, enable
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // Management register access
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [4:0] I_REG_ADDR,
    input wire logic [15:0] I_REG_WDATA,
    output logic [15:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    // Shared sleep_or_irq_pin
    input wire logic I_SLEEP_OR_IRQ_PIN,
    output logic O_SLEEP_OR_IRQ_PIN,
    output logic O_SLEEP_OR_IRQ_PIN_OE,
    // Line status
    input wire logic I_LINK_UP,
    input wire logic I_LINE_ACTIVITY,
    // Power state
    output logic O_POWER_DOWN,
    output logic O_LOW_POWER,
    output logic O_ED_PULSE
);
    spi_req_t req;
    logic [15:0] basic_control_reg;
    logic [15:0] interrupt_pin_control;
    logic [NUM_SOURCES-1:0] irq_mask;
    logic [15:0] energy_saving_control;
    logic strap_taken;
    logic strap_down;
    logic link_prev;
    logic [NUM_SOURCES-1:0] flags;
    logic ed_low_power;
    logic ed_pulse;
    logic ed_change;

    assign req = '{wr: I_REG_WR, rd: I_REG_RD, addr: I_REG_ADDR, wdata: I_REG_WDATA};

    wire wr_basic = req.wr && (req.addr == ADDR_BASIC_CONTROL);
    wire wr_pin = req.wr && (req.addr == ADDR_PIN_CONTROL);
    wire wr_mask = req.wr && (req.addr == ADDR_MASK_STATUS);
    wire wr_energy = req.wr && (req.addr == ADDR_ENERGY_CONTROL);
    wire rd_status = I_CE && req.rd && (req.addr == ADDR_MASK_STATUS);

    wire pin_oe = interrupt_pin_control[BIT_PIN_OE];
    wire irq_en = interrupt_pin_control[BIT_IRQ_ENABLE];
    wire energy_en = energy_saving_control[BIT_ENERGY_ENABLE];

    // In input mode a low pin requests power-down; the enable bit masks it.
    wire pin_down = !pin_oe && !I_SLEEP_OR_IRQ_PIN;
    wire next_power_down = basic_control_reg[BIT_POWER_DOWN] || pin_down
        || (strap_down && !pin_oe);

    wire link_change = (I_LINK_UP != link_prev);
    logic [NUM_SOURCES-1:0] events;
    always_comb begin
        events = '0;
        events[SRC_LINK] = link_change;
        events[SRC_ENERGY] = ed_change;
    end

    // A status read drops old flags, but an event in the read cycle still sets its flag.
    // The pin therefore stays low through such a read instead of glitching high.
    wire [NUM_SOURCES-1:0] next_flags = rd_status ? events : (flags | events);
    wire irq_active = pin_oe && irq_en && |(next_flags & irq_mask);

    wire [15:0] status_word = {flags, irq_mask};
    wire [15:0] next_rdata =
        (req.addr == ADDR_BASIC_CONTROL) ? basic_control_reg :
        (req.addr == ADDR_PIN_CONTROL) ? interrupt_pin_control :
        (req.addr == ADDR_MASK_STATUS) ? status_word :
        (req.addr == ADDR_ENERGY_CONTROL) ? energy_saving_control : RESET_ZERO;

    spi_irq_flags u_flags (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_ce(I_CE),
        .i_event(events),
        .i_clear(rd_status),
        .o_flags(flags)
    );

    spi_energy_detect u_ed (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_ce(I_CE),
        .i_enable(energy_en),
        .i_activity(I_LINE_ACTIVITY),
        .o_low_power(ed_low_power),
        .o_pulse(ed_pulse),
        .o_state_change(ed_change)
    );

    // Registers stay writable in power-down.
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            basic_control_reg <= RESET_ZERO;
            interrupt_pin_control <= RESET_ZERO;
            irq_mask <= '0;
            energy_saving_control <= RESET_ZERO;
        end else if (I_CE) begin
            if (wr_basic) begin
                basic_control_reg <= req.wdata;
            end
            if (wr_pin) begin
                interrupt_pin_control <= req.wdata;
            end
            if (wr_mask) begin
                irq_mask <= req.wdata[NUM_SOURCES-1:0];
            end
            if (wr_energy) begin
                energy_saving_control <= req.wdata;
            end
        end
    end

    // The strap is caught on the first enabled edge after reset release.
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            strap_taken <= 1'b0;
            strap_down <= 1'b0;
            link_prev <= 1'b0;
        end else if (I_CE) begin
            link_prev <= I_LINK_UP;
            if (!strap_taken) begin
                strap_taken <= 1'b1;
                strap_down <= !I_SLEEP_OR_IRQ_PIN;
            end else if (pin_oe || wr_basic) begin
                strap_down <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_SLEEP_OR_IRQ_PIN <= 1'b1;
            O_SLEEP_OR_IRQ_PIN_OE <= 1'b0;
            O_POWER_DOWN <= 1'b0;
            O_LOW_POWER <= 1'b0;
            O_ED_PULSE <= 1'b0;
            O_REG_RDATA <= RESET_ZERO;
            O_REG_RVALID <= 1'b0;
        end else if (I_CE) begin
            O_SLEEP_OR_IRQ_PIN_OE <= pin_oe;
            O_SLEEP_OR_IRQ_PIN <= !irq_active;
            O_POWER_DOWN <= next_power_down;
            O_LOW_POWER <= ed_low_power;
            O_ED_PULSE <= ed_pulse;
            O_REG_RVALID <= req.rd;
            if (req.rd) begin
                O_REG_RDATA <= next_rdata;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/spi_host_model.sv
// Host side of the shared pin: the weak pull-up and an external low drive.
// Assumes the bench sets the low drive just after I_CLK edges.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // Pin as driven by the block
    input wire logic i_pin_out,
    input wire logic i_pin_oe,
    // Bench command and resolved wire
    input wire logic i_hold_low,
    output logic o_pin
);
    // The pull-up sets the level only while nobody drives the wire.
    assign o_pin = i_pin_oe ? i_pin_out : !i_hold_low;
endmodule
`default_nettype wire

// ===== tb/spi_powerdown_irq_chk.sv
// Checker for the shared pin block; sees only its top ports.
// Assumes nothing is judged while the clock enable is low.
`timescale 1ns/1ps
`default_nettype none
module spi_powerdown_irq_chk
    import spi_pkg::*;
(
    // Clock and register access
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [4:0] I_REG_ADDR,
    input wire logic [15:0] I_REG_WDATA,
    input wire logic O_REG_RVALID,
    // Pin, line and power
    input wire logic I_SLEEP_OR_IRQ_PIN,
    input wire logic O_SLEEP_OR_IRQ_PIN,
    input wire logic O_SLEEP_OR_IRQ_PIN_OE,
    input wire logic I_LINK_UP,
    input wire logic I_LINE_ACTIVITY,
    input wire logic O_POWER_DOWN,
    input wire logic O_LOW_POWER
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST || !I_CE);
    logic [1:0] ctl;
    logic msk;
    logic ed;
    wire logic rd_st = I_REG_RD && I_REG_ADDR == ADDR_MASK_STATUS;
    // Shadows of the control bits, so the pin can be judged against them.
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            ctl <= 2'h0;
            msk <= 1'b0;
            ed <= 1'b0;
        end else if (I_CE && I_REG_WR) begin
            if (I_REG_ADDR == ADDR_PIN_CONTROL) ctl <= I_REG_WDATA[1:0];
            if (I_REG_ADDR == ADDR_MASK_STATUS) msk <= I_REG_WDATA[SRC_LINK];
            if (I_REG_ADDR == ADDR_ENERGY_CONTROL) ed <= I_REG_WDATA[BIT_ENERGY_ENABLE];
        end
    end
    a_read_answered: assert property (I_REG_RD |=> O_REG_RVALID)
        else $error("read not answered");
    a_oe_mirrors_bit: assert property (O_SLEEP_OR_IRQ_PIN_OE == $past(ctl[BIT_PIN_OE]))
        else $error("pin enable differs from its bit");
    a_low_needs_enables: assert property (!O_SLEEP_OR_IRQ_PIN |-> $past(ctl) == 2'h3)
        else $error("pin low without both enables");
    a_link_raises_irq: assert property (ctl == 2'h3 && msk && $changed(I_LINK_UP)
        |=> !O_SLEEP_OR_IRQ_PIN) else $error("link change did not pull pin low");
    a_read_releases: assert property (rd_st && $stable(I_LINK_UP)
        |=> O_SLEEP_OR_IRQ_PIN || $changed(O_LOW_POWER)) else $error("pin not released");
    a_pin_powers_down: assert property (!ctl[BIT_PIN_OE] && !I_SLEEP_OR_IRQ_PIN
        && !I_REG_WR |-> ##[1:2] O_POWER_DOWN) else $error("low pin did not power down");
    a_sleeps_when_idle: assert property (ed && !I_LINE_ACTIVITY
        |-> ##[1:402] O_LOW_POWER) else $error("idle line not in low power");
    a_wakes_on_activity: assert property (O_LOW_POWER && I_LINE_ACTIVITY
        |-> ##[1:402] !O_LOW_POWER) else $error("activity did not wake");
endmodule
`default_nettype wire

// ===== tb/spi_powerdown_irq_tb.sv
// Self-checking bench for the shared power-down / interrupt pin block.
// Assumes the host model resolves the pin wire; the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
module spi_powerdown_irq_tb
    import spi_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, link = 1'b0, act = 1'b1, hold = 1'b0;
    logic ce = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic pin, pin_out, pin_oe, pd, lp, rvalid, pulse;
    int n_errors = 0, n_compared = 0;
    always #12.5 clk = !clk;
    spi_powerdown_irq spi_powerdown_irq_inst (
        .I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
        .I_SLEEP_OR_IRQ_PIN(pin), .O_SLEEP_OR_IRQ_PIN(pin_out), .O_SLEEP_OR_IRQ_PIN_OE(pin_oe),
        .I_LINK_UP(link), .I_LINE_ACTIVITY(act), .O_POWER_DOWN(pd), .O_LOW_POWER(lp),
        .O_ED_PULSE(pulse));
    spi_host_model spi_host_model_inst (
        .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_hold_low(hold), .o_pin(pin));
    task automatic results();
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({15'h0000, rvalid}, 16'h0001);
        chk(rdata, exp);
        @(posedge clk);
    endtask
    // Waits for the pin (0), low power (1) or power-down (2) to reach a level.
    task automatic wait_for(input int sel, input logic exp);
        for (int n = 0; n < 600; n++) begin
            #1;
            if ((sel == 0 ? pin : sel == 1 ? lp : pd) === exp) begin
                n_compared++;
                @(posedge clk);
                return;
            end
            @(posedge clk);
        end
        n_errors++;
        $display("wrong value at %0t: wait ran out", $time);
        results();
    endtask
    task automatic t_defaults();
        #1;
        chk({13'h0000, pin_oe, pd, pulse}, 16'h0000);
        @(posedge clk);
        rd_chk(ADDR_PIN_CONTROL, RESET_ZERO);
        rd_chk(ADDR_MASK_STATUS, RESET_ZERO);
        rd_chk(5'h05, RESET_ZERO);
    endtask
    task automatic t_pin_pd();
        hold <= 1'b1;
        wait_for(2, 1'b1);
        rd_chk(ADDR_PIN_CONTROL, RESET_ZERO);
        wr_reg(ADDR_PIN_CONTROL, 16'h0001);
        wait_for(2, 1'b0);
        hold <= 1'b0;
        wr_reg(ADDR_PIN_CONTROL, 16'h0000);
    endtask
    task automatic t_link();
        wr_reg(ADDR_PIN_CONTROL, 16'h0003);
        wr_reg(ADDR_MASK_STATUS, 16'hff60);
        rd_chk(ADDR_MASK_STATUS, 16'h0060);
        link <= 1'b1;
        wait_for(0, 1'b0);
        rd_chk(ADDR_MASK_STATUS, 16'h2060);
        wait_for(0, 1'b1);
        rd_chk(ADDR_MASK_STATUS, 16'h0060);
        wr_reg(ADDR_PIN_CONTROL, 16'h0001);
        link <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({15'h0000, pin}, 16'h0001);
        @(posedge clk);
        rd_chk(ADDR_MASK_STATUS, 16'h2060);
    endtask
    task automatic t_energy();
        wr_reg(ADDR_PIN_CONTROL, 16'h0003);
        act <= 1'b0;
        wr_reg(ADDR_ENERGY_CONTROL, 16'h8000);
        wait_for(1, 1'b1);
        wait_for(0, 1'b0);
        rd_chk(ADDR_MASK_STATUS, 16'h4060);
        act <= 1'b1;
        wait_for(1, 1'b0);
        wait_for(0, 1'b0);
        rd_chk(ADDR_MASK_STATUS, 16'h4060);
        wr_reg(ADDR_ENERGY_CONTROL, 16'h0000);
    endtask
    // A link change while the clock enable is low must wait until it returns.
    task automatic t_freeze();
        ce <= 1'b0;
        link <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({15'h0000, pin}, 16'h0001);
        @(posedge clk);
        ce <= 1'b1;
        wait_for(0, 1'b0);
        rd_chk(ADDR_MASK_STATUS, 16'h2060);
    endtask
    task automatic t_strap();
        hold <= 1'b1;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wait_for(2, 1'b1);
        hold <= 1'b0;
        wr_reg(ADDR_BASIC_CONTROL, 16'h0000);
        wait_for(2, 1'b0);
        wr_reg(ADDR_BASIC_CONTROL, 16'h0800);
        wait_for(2, 1'b1);
        rd_chk(ADDR_BASIC_CONTROL, 16'h0800);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_defaults();
        t_pin_pd();
        t_link();
        t_energy();
        t_freeze();
        t_strap();
        results();
    end
endmodule
bind spi_powerdown_irq spi_powerdown_irq_chk spi_powerdown_irq_chk_inst (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
    .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .O_REG_RVALID(O_REG_RVALID),
    .I_SLEEP_OR_IRQ_PIN(I_SLEEP_OR_IRQ_PIN), .O_SLEEP_OR_IRQ_PIN(O_SLEEP_OR_IRQ_PIN),
    .O_SLEEP_OR_IRQ_PIN_OE(O_SLEEP_OR_IRQ_PIN_OE), .I_LINK_UP(I_LINK_UP),
    .I_LINE_ACTIVITY(I_LINE_ACTIVITY), .O_POWER_DOWN(O_POWER_DOWN), .O_LOW_POWER(O_LOW_POWER));
`default_nettype wire
